/* File: sample_rate_and_selftest_trim.sv */
// sample rate tick generator with self-test trim registers on apb
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
//
// Behaviour
// - gyro trim code in bits 4:0
// - accel trim split upper/lower, reserved bits zero
// - self-test enable actuates the axis element
// - sample rate is gyro rate over divider+1
// - gyro rate 8 kHz if filter off, else 1 kHz
// - outputs paced by the single sample tick
// - accel at 1 kHz, latest sample repeated
// - lowpass setting is a 3-bit field
// - registers reset to zero
module sample_rate_and_selftest_trim #(
    parameter int FAST_CYCLES = srt_pkg::FAST_RATE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // sensor element samples, same clock domain
    input wire logic [47:0] gyro_data_i,
    input wire logic [47:0] accel_data_i,
    // paced outputs and self-test drive
    output logic sample_tick_o,
    output logic [47:0] gyro_out_o,
    output logic [47:0] accel_out_o,
    output logic [2:0] gyro_st_drive_o,
    output logic [2:0] accel_st_drive_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] trim_x, trim_y, trim_z;
    logic [5:0] trim_accel_low;
    logic [7:0] rate_divider_value;
    logic [2:0] lowpass_setting;
    logic mapped, wr_en, rd_setup;
    logic [7:0] rd_val;
    logic [31:0] fast_cnt;
    logic [2:0] slow_phase;
    logic fast_strobe, slow_strobe, gyro_strobe;
    logic [7:0] div_cnt;
    logic [47:0] accel_hold;

    // address decode and read mux
    always_comb begin
        mapped = 1'b1;
        rd_val = 8'h00;
        if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_TRIM_X)) begin
            rd_val = trim_x;
        end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_TRIM_Y)) begin
            rd_val = trim_y;
        end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_TRIM_Z)) begin
            rd_val = trim_z;
        end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_TRIM_ACCEL_LOW)) begin
            rd_val = {2'b00, trim_accel_low};
        end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_DIVIDER)) begin
            rd_val = rate_divider_value;
        end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_CONFIG)) begin
            rd_val = {5'h00, lowpass_setting};
        end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_GYRO_ST)) begin
            rd_val = {gyro_st_drive_o, 5'h00};
        end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_ACCEL_ST)) begin
            rd_val = {accel_st_drive_o, 5'h00};
        end else begin
            mapped = 1'b0;
        end
    end

    // zero wait state slave, error on unmapped access
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign wr_en = psel_i && penable_i && pwrite_i && mapped;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;

    // read data captured in the setup cycle
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_o <= {24'h00_0000, rd_val};
        end
    end

    // register writes
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trim_x <= srt_pkg::REG_RESET;
            trim_y <= srt_pkg::REG_RESET;
            trim_z <= srt_pkg::REG_RESET;
            trim_accel_low <= srt_pkg::REG_RESET[5:0];
            rate_divider_value <= srt_pkg::REG_RESET;
            lowpass_setting <= srt_pkg::REG_RESET[2:0];
            gyro_st_drive_o <= srt_pkg::REG_RESET[2:0];
            accel_st_drive_o <= srt_pkg::REG_RESET[2:0];
        end else if (wr_en) begin
            if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_TRIM_X)) begin
                trim_x <= pwdata_i[7:0];
            end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_TRIM_Y)) begin
                trim_y <= pwdata_i[7:0];
            end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_TRIM_Z)) begin
                trim_z <= pwdata_i[7:0];
            end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_TRIM_ACCEL_LOW)) begin
                trim_accel_low <= pwdata_i[5:0];
            end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_DIVIDER)) begin
                rate_divider_value <= pwdata_i[7:0];
            end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_CONFIG)) begin
                lowpass_setting <= pwdata_i[srt_pkg::LOWPASS_LSB +: 3];
            end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_GYRO_ST)) begin
                gyro_st_drive_o <= pwdata_i[srt_pkg::ST_EN_LSB +: 3];
            end else if (srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_ACCEL_ST)) begin
                accel_st_drive_o <= pwdata_i[srt_pkg::ST_EN_LSB +: 3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 8 kHz base strobe from the system clock
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fast_cnt <= 32'h0000_0000;
        end else if (fast_strobe) begin
            fast_cnt <= 32'h0000_0000;
        end else begin
            fast_cnt <= fast_cnt + 32'h0000_0001;
        end
    end
    assign fast_strobe = fast_cnt == 32'(FAST_CYCLES - 1);

    // 1 kHz strobe, every eighth fast strobe
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            slow_phase <= 3'h0;
        end else if (fast_strobe) begin
            slow_phase <= slow_phase + 3'h1;
        end
    end
    assign slow_strobe = fast_strobe && (slow_phase == 3'(srt_pkg::FAST_PER_SLOW - 1));

    // gyro output rate picked by the lowpass setting
    assign gyro_strobe = srt_pkg::fast_rate(lowpass_setting) ? fast_strobe : slow_strobe;

    // divider counter, divider changes land at the next reload
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt <= 8'h00;
        end else if (gyro_strobe) begin
            if (div_cnt == 8'h00) begin
                div_cnt <= rate_divider_value;
            end else begin
                div_cnt <= div_cnt - 8'h01;
            end
        end
    end

    // accel sample taken at 1 kHz and held between
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            accel_hold <= 48'h0000_0000_0000;
        end else if (slow_strobe) begin
            accel_hold <= accel_data_i;
        end
    end

    // tick and output registers updated together
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sample_tick_o <= 1'b0;
            gyro_out_o <= 48'h0000_0000_0000;
            accel_out_o <= 48'h0000_0000_0000;
        end else begin
            sample_tick_o <= gyro_strobe && (div_cnt == 8'h00);
            if (gyro_strobe && (div_cnt == 8'h00)) begin
                gyro_out_o <= gyro_data_i;
                accel_out_o <= accel_hold;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    a_tick_on_reload: assert property (
        gyro_strobe && div_cnt == 8'h00 |=> sample_tick_o)
        else $error("no tick at divider reload");
    a_reload_value: assert property (
        gyro_strobe && div_cnt == 8'h00 |=> div_cnt == $past(rate_divider_value))
        else $error("divider not reloaded");
    a_count_down: assert property (
        gyro_strobe && div_cnt != 8'h00 |=> div_cnt == $past(div_cnt) - 8'h01 && !sample_tick_o)
        else $error("divider count wrong");
    a_slow_rate: assert property (
        gyro_strobe && !srt_pkg::fast_rate(lowpass_setting) |-> slow_phase == 3'h7)
        else $error("gyro strobe too fast with filter on");
    a_outputs_paced: assert property (
        $changed(gyro_out_o) || $changed(accel_out_o) |-> sample_tick_o)
        else $error("outputs changed without tick");
    a_accel_held: assert property (
        $changed(accel_hold) |-> $past(slow_strobe))
        else $error("accel sample changed off 1 kHz");
    a_reserved_zero: assert property (
        rd_setup && srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_TRIM_ACCEL_LOW)
        |=> prdata_o[31:6] == 26'h000_0000)
        else $error("reserved trim bits not zero");
    a_st_drive: assert property (
        wr_en && srt_pkg::reg_hit(paddr_i, srt_pkg::IDX_GYRO_ST)
        |=> gyro_st_drive_o == $past(pwdata_i[7:5]))
        else $error("gyro self-test drive not applied");

    c_fast_tick: cover property (sample_tick_o && srt_pkg::fast_rate(lowpass_setting));
    c_slow_tick: cover property (sample_tick_o && !srt_pkg::fast_rate(lowpass_setting));
    c_bad_addr: cover property (pslverr_o);
endmodule // sample_rate_and_selftest_trim

/* File: srt_pkg.sv */
// constants for the sample rate tick and self-test trim block
package srt_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_TRIM_X = 8'h0D;
    localparam logic [7:0] IDX_TRIM_Y = 8'h0E;
    localparam logic [7:0] IDX_TRIM_Z = 8'h0F;
    localparam logic [7:0] IDX_TRIM_ACCEL_LOW = 8'h10;
    localparam logic [7:0] IDX_DIVIDER = 8'h19;
    localparam logic [7:0] IDX_CONFIG = 8'h1A;
    localparam logic [7:0] IDX_GYRO_ST = 8'h1B;
    localparam logic [7:0] IDX_ACCEL_ST = 8'h1C;
    // reset value of every register here
    localparam logic [7:0] REG_RESET = 8'h00;
    // field positions
    localparam int GYRO_TRIM_LSB = 0;
    localparam int ACCEL_HI_LSB = 5;
    localparam int ST_EN_LSB = 5;
    localparam int LOWPASS_LSB = 0;
    // lowpass settings that disable the filter
    localparam logic [2:0] LOWPASS_OFF_A = 3'h0;
    localparam logic [2:0] LOWPASS_OFF_B = 3'h7;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FAST_RATE_PERIOD_NS = 125000;
    localparam int SLOW_RATE_PERIOD_NS = 1000000;
    localparam int FAST_RATE_CYCLES = FAST_RATE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FAST_PER_SLOW = SLOW_RATE_PERIOD_NS / FAST_RATE_PERIOD_NS;

    // filter off means the gyro runs at the fast rate
    function automatic logic fast_rate(input logic [2:0] lp);
        return (lp == LOWPASS_OFF_A) || (lp == LOWPASS_OFF_B);
    endfunction

    // apb word address match for a register index
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] idx);
        return addr == {idx[5:0], 2'b00};
    endfunction
endpackage

/* File: sample_rate_and_selftest_trim_tb.sv */
// self-checking bench for the sample tick and self-test trim block
`timescale 1ns/1ps
module sample_rate_and_selftest_trim_tb;
    localparam int FC = 20;
    // pass window on the relative self-test deviation, a plain default
    localparam real ST_LIMIT = 0.14;
    logic sys_clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic pready_o, pslverr_o, sample_tick_o;
    logic [47:0] gyro_data_i = 48'h0, accel_data_i = 48'h0, gyro_out_o, accel_out_o, prev_gyro;
    logic [2:0] gyro_st_drive_o, accel_st_drive_o;
    int err_total = 0, checks_done = 0;
    // element model: running count above, self-test shift in the x fields
    logic [31:0] elem_cnt = 32'h0000_0000;
    logic [15:0] gyro_st_shift = 16'h0000, accel_st_shift = 16'h0000;

    sample_rate_and_selftest_trim #(.FAST_CYCLES(FC)) i_sample_rate_and_selftest_trim (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .gyro_data_i(gyro_data_i),
        .accel_data_i(accel_data_i), .sample_tick_o(sample_tick_o), .gyro_out_o(gyro_out_o),
        .accel_out_o(accel_out_o), .gyro_st_drive_o(gyro_st_drive_o),
        .accel_st_drive_o(accel_st_drive_o));

    // clock and ever-changing element samples
    initial forever #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        elem_cnt <= elem_cnt + 32'h0000_0001;
        gyro_data_i <= {elem_cnt, gyro_st_drive_o[2] ? gyro_st_shift : 16'h0000};
        accel_data_i <= {elem_cnt + 32'h0000_0005,
                         accel_st_drive_o[2] ? accel_st_shift : 16'h0000};
        prev_gyro <= gyro_data_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %0h want %0h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= {idx[5:0], 2'b00};
        pwdata_i <= wd;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin @(posedge sys_clk_i); n++; end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) begin err_total++; complete_run(); end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, {24'h0, v}, d, e);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic exp_err);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 32'h0, d, e);
        chk({16'h0, d}, {40'h0, exp}, "read data");
        chk({47'h0, e}, {47'h0, exp_err}, "error flag");
    endtask

    // counts cycles up to the next tick and checks the paced gyro sample
    task automatic next_tick(output int n);
        n = 0;
        do begin @(posedge sys_clk_i); #1; n++; end while (sample_tick_o !== 1'b1 && n < 5000);
        if (n >= 5000) begin err_total++; complete_run(); end
        chk(gyro_out_o, prev_gyro, "gyro sample at tick");
    endtask

    task automatic tick_gap(input int exp);
        int n;
        repeat (3) next_tick(n);
        chk(48'(n), 48'(exp), "tick spacing");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd_chk(srt_pkg::IDX_TRIM_X, 8'h00, 1'b0);
        rd_chk(srt_pkg::IDX_TRIM_ACCEL_LOW, 8'h00, 1'b0);
        rd_chk(srt_pkg::IDX_DIVIDER, 8'h00, 1'b0);
        wr(srt_pkg::IDX_TRIM_X, 8'hFF);
        wr(srt_pkg::IDX_TRIM_Y, 8'hA5);
        wr(srt_pkg::IDX_TRIM_Z, 8'h3C);
        wr(srt_pkg::IDX_TRIM_ACCEL_LOW, 8'hFF);
        rd_chk(srt_pkg::IDX_TRIM_X, 8'hFF, 1'b0);
        rd_chk(srt_pkg::IDX_TRIM_Y, 8'hA5, 1'b0);
        rd_chk(srt_pkg::IDX_TRIM_Z, 8'h3C, 1'b0);
        rd_chk(srt_pkg::IDX_TRIM_ACCEL_LOW, 8'h3F, 1'b0);
        wr(8'h05, 8'h77);
        rd_chk(8'h05, 8'h00, 1'b1);
        $display("test registers done");
    endtask

    task automatic t_rates();
        for (int lp = 0; lp < 8; lp++) begin
            wr(srt_pkg::IDX_CONFIG, 8'(lp));
            tick_gap((lp == 0 || lp == 7) ? FC : 8 * FC);
        end
        wr(srt_pkg::IDX_CONFIG, 8'h01);
        wr(srt_pkg::IDX_DIVIDER, 8'h01);
        tick_gap(2 * 8 * FC);
        wr(srt_pkg::IDX_CONFIG, 8'h00);
        wr(srt_pkg::IDX_DIVIDER, 8'h02);
        tick_gap(3 * FC);
        $display("test rates done");
    endtask

    // fast ticks repeat the 1 kHz accel sample: one change in eight ticks
    task automatic t_accel();
        int n, changes;
        logic [47:0] last;
        wr(srt_pkg::IDX_DIVIDER, 8'h00);
        repeat (3) next_tick(n);
        last = accel_out_o;
        changes = 0;
        repeat (8) begin
            next_tick(n);
            if (accel_out_o !== last) changes++;
            last = accel_out_o;
        end
        chk(48'(changes), 48'h1, "accel repeats");
        $display("test accel done");
    endtask

    // self-test: expected response from the trim codes, judged on the x axes
    task automatic t_selftest();
        logic [31:0] d;
        logic e;
        int n, gyro_x_trim_code, accel_x_trim_code;
        logic [47:0] gyro_off, accel_off;
        real gyro_expected, accel_expected, gyro_resp, accel_resp, dev;
        apb(1'b0, srt_pkg::IDX_TRIM_X, 32'h0, d, e);
        gyro_x_trim_code = int'(d[srt_pkg::GYRO_TRIM_LSB +: 5]);
        accel_x_trim_code = int'(d[srt_pkg::ACCEL_HI_LSB +: 3]) * 4;
        apb(1'b0, srt_pkg::IDX_TRIM_ACCEL_LOW, 32'h0, d, e);
        accel_x_trim_code = accel_x_trim_code + int'(d[5:4]);
        chk(48'(gyro_x_trim_code), 48'h1F, "gyro trim code");
        chk(48'(accel_x_trim_code), 48'h1F, "accel trim code");
        gyro_expected = 0.0;
        accel_expected = 0.0;
        if (gyro_x_trim_code != 0) begin
            gyro_expected = 25.0 * 131.0 * $pow(1.046, real'(gyro_x_trim_code - 1));
        end
        if (accel_x_trim_code != 0) begin
            accel_expected = 4096.0 * 0.34
                * $pow(0.92 / 0.34, real'(accel_x_trim_code - 1) / 30.0);
        end
        gyro_st_shift <= 16'($rtoi(gyro_expected));
        accel_st_shift <= 16'($rtoi(accel_expected));
        wr(srt_pkg::IDX_GYRO_ST, 8'h00);
        wr(srt_pkg::IDX_ACCEL_ST, 8'h10);
        repeat (2) next_tick(n);
        gyro_off = gyro_out_o;
        accel_off = accel_out_o;
        wr(srt_pkg::IDX_GYRO_ST, 8'hA0);
        wr(srt_pkg::IDX_ACCEL_ST, 8'h90);
        @(posedge sys_clk_i);
        #1;
        chk({45'h0, gyro_st_drive_o}, 48'h5, "gyro self-test drive");
        chk({45'h0, accel_st_drive_o}, 48'h4, "accel self-test drive");
        // ten fast ticks cover one 1 kHz accel sample plus its output tick
        repeat (10) next_tick(n);
        gyro_resp = real'($signed(gyro_out_o[15:0])) - real'($signed(gyro_off[15:0]));
        accel_resp = real'($signed(accel_out_o[15:0])) - real'($signed(accel_off[15:0]));
        dev = (gyro_resp - gyro_expected) / gyro_expected;
        chk(48'(dev <= ST_LIMIT && dev >= -ST_LIMIT), 48'h1, "gyro self-test deviation");
        dev = (accel_resp - accel_expected) / accel_expected;
        chk(48'(dev <= ST_LIMIT && dev >= -ST_LIMIT), 48'h1, "accel self-test deviation");
        $display("test self-test done");
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_rates();
        t_accel();
        t_selftest();
        complete_run();
    end
endmodule // sample_rate_and_selftest_trim_tb
